// ==== rtl/slb_logic_core.sv ====
// Purpose: Boolean logic blocks, latches, dual-channel decode and bypass
// Assumes: gate and latch inputs come from logic on clk; channel pins are
//          asynchronous and are synchronised here
// Notes: all outputs are registered, one clock behind their inputs; chanRun is three clocks behind the pins
//        the bypass timer counts in one-second enable pulses
//
// Summary of operation
// - AND output On only while every connected input (2 to 5) is On.
// - OR output On when any connected input is On, Off when all Off.
// - NAND output Off only when every connected input is On.
// - NOR output On only when every connected input is Off.
// - XOR output On only when exactly one connected input is On.
// - NOT output is always the complement of its input.
// - reset-dominant latch holds, sets, clears; both On clears.
// - set-dominant latch holds, sets, clears; both On sets.
// - optional inversion of gate inputs or output makes Stop count as true.
// - bypass output follows monitored input while bypass request is inactive.
// - bypass output On while request active and limit not yet expired.
// - on timer expiry output turns Off and control returns to the input.
// - limit ranges 1 s to 12 h; no setting disables it.
// - one shared limit value applies to every bypassed input.
// - actuating a bypassed two-hand input gives Stop, not bypass On.
// - dual channels decode to Run: both high, or complementary high/low.
`timescale 1ns/10ps
module slb_logic_core
  import slb_pkg::*;
#(
  parameter int unsigned NUM_IN = slb_pkg::GATE_MAX_IN,
  parameter int unsigned SEC_TICKS = slb_pkg::SEC_CYCLES
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // configurable gate
  input wire logic [NUM_IN-1:0] gateIn,
  input wire logic [NUM_IN-1:0] gateUsed,
  input wire logic [NUM_IN-1:0] gateInvertIn,
  input wire logic gateInvertOut,
  input wire slb_pkg::slb_gate_op_t gateOp,
  output logic gateOut,
  // single-input inverter
  input wire logic notIn,
  output logic notOut,
  // latches
  input wire logic latchSet,
  input wire logic latchReset,
  output logic rsOut,
  output logic srOut,
  // dual-channel safety input pins
  input wire logic chanA,
  input wire logic chanB,
  input wire logic chanComplementary,
  output logic chanRun,
  // bypass block
  input wire logic bypass_request_node,
  input wire logic twoHandInput,
  input wire logic [slb_pkg::LIMIT_W-1:0] bypassLimitSec,
  output logic bypassOut,
  output logic bypassActive,
  output logic bypassExpired
);
  import slb_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // configurable gate
  ////////////////////////////////////////////////////////////////////////

  logic [NUM_IN-1:0] gateEff;
  logic [2:0] onCount [0:NUM_IN];
  logic [2:0] usedCount [0:NUM_IN];

  // per-input inversion and counting of On inputs
  assign onCount[0] = 3'h0;
  assign usedCount[0] = 3'h0;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++)
    begin : g_in
      assign gateEff[gi] = gateIn[gi] ^ gateInvertIn[gi];
      assign onCount[gi+1] = onCount[gi]
        + {2'h0, gateEff[gi] & gateUsed[gi]};
      assign usedCount[gi+1] = usedCount[gi] + {2'h0, gateUsed[gi]};
    end
  endgenerate

  wire logic [2:0] onTotal = onCount[NUM_IN];
  wire logic [2:0] usedTotal = usedCount[NUM_IN];
  // fewer than two connected inputs is an unconfigured gate
  wire logic enoughIn = usedTotal >= GATE_MIN_IN_W;
  wire logic allOn = enoughIn && (onTotal == usedTotal);
  wire logic anyOn = enoughIn && (onTotal != 3'h0);
  wire logic oneOn = enoughIn && (onTotal == 3'h1);

  // one named result per gate function
  wire logic andRaw = allOn;
  wire logic orRaw = anyOn;
  wire logic nandRaw = enoughIn && !allOn;
  wire logic norRaw = enoughIn && !anyOn;
  wire logic xorRaw = oneOn;

  logic gateRaw;
  always_comb
  begin
    gateRaw = 1'b0;
    unique case (gateOp)
      SLB_AND: gateRaw = andRaw;
      SLB_OR: gateRaw = orRaw;
      SLB_NAND: gateRaw = nandRaw;
      SLB_NOR: gateRaw = norRaw;
      SLB_XOR: gateRaw = xorRaw;
      default: gateRaw = 1'b0;
    endcase
  end

  // an unconfigured gate (fewer than two inputs) sits Off
  wire logic next_gateOut = enoughIn && (gateRaw ^ gateInvertOut);

  always_ff @(posedge clk)
  begin
    if (rst)
      gateOut <= OUT_RST;
    else
      gateOut <= next_gateOut;
  end

  ////////////////////////////////////////////////////////////////////////
  // inverter and latches
  ////////////////////////////////////////////////////////////////////////

  wire logic next_notOut = !notIn;
  wire logic next_rsOut = !latchReset && (latchSet || rsOut);
  wire logic next_srOut = latchSet || (!latchReset && srOut);

  // each output its own register, so the two priorities stay apart
  always_ff @(posedge clk)
  begin
    if (rst)
      notOut <= OUT_RST;
    else
      notOut <= next_notOut;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      rsOut <= OUT_RST;
    else
      rsOut <= next_rsOut;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      srOut <= OUT_RST;
    else
      srOut <= next_srOut;
  end

  ////////////////////////////////////////////////////////////////////////
  // dual-channel decode
  ////////////////////////////////////////////////////////////////////////

  logic chanAMeta;
  logic chanASync;
  logic chanBMeta;
  logic chanBSync;

  // two flops per pin; only the second flop feeds the decode
  always_ff @(posedge clk)
  begin
    if (rst)
      chanAMeta <= 1'b0;
    else
      chanAMeta <= chanA;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      chanASync <= 1'b0;
    else
      chanASync <= chanAMeta;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      chanBMeta <= 1'b0;
    else
      chanBMeta <= chanB;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      chanBSync <= 1'b0;
    else
      chanBSync <= chanBMeta;
  end

  // complementary devices run with A high and B low
  wire logic chanBRun = chanComplementary ? !chanBSync : chanBSync;
  wire logic next_chanRun = chanASync && chanBRun;

  always_ff @(posedge clk)
  begin
    if (rst)
      chanRun <= OUT_RST;
    else
      chanRun <= next_chanRun;
  end

  ////////////////////////////////////////////////////////////////////////
  // bypass time limit
  ////////////////////////////////////////////////////////////////////////

  // one limit serves every bypassed input
  // zero or out-of-range settings are pulled into the legal span
  wire logic limitLow = bypassLimitSec < LIMIT_MIN_SEC;
  wire logic limitHigh = bypassLimitSec > LIMIT_MAX_SEC;
  wire logic [LIMIT_W-1:0] limitSec = limitLow ? LIMIT_MIN_SEC
    : (limitHigh ? LIMIT_MAX_SEC : bypassLimitSec);

  localparam logic [DIV_W-1:0] TICK_LAST = DIV_W'(SEC_TICKS - 1);

  slb_bp_state_t bpState;
  slb_bp_state_t next_bpState;
  logic [DIV_W-1:0] divCount;
  logic [LIMIT_W-1:0] remainSec;

  wire logic tick = (divCount == TICK_LAST);
  wire logic lastSec = (remainSec == LIMIT_MIN_SEC);
  wire logic expireNow = tick && lastSec;
  wire logic startBypass = (bpState == SLB_PASS) && bypass_request_node;

  always_comb
  begin
    next_bpState = bpState;
    unique case (bpState)
      SLB_PASS:
        if (bypass_request_node)
          next_bpState = SLB_BYPASS;
      SLB_BYPASS:
        if (!bypass_request_node)
          next_bpState = SLB_PASS;
        else if (expireNow)
          next_bpState = SLB_EXPIRED;
      SLB_EXPIRED:
        if (!bypass_request_node)
          next_bpState = SLB_PASS;
    endcase
  end

  // one-second enable pulse, restarted with every new bypass
  wire logic [DIV_W-1:0] next_divCount = (startBypass || tick)
    ? DIV_RST : divCount + DIV_W'(1);
  wire logic [LIMIT_W-1:0] next_remainSec = startBypass ? limitSec
    : (tick ? remainSec - LIMIT_W'(1) : remainSec);

  // the divider only runs inside a bypass, so each starts a full second
  // remainSec holds whole seconds left and reloads only on a fresh entry
  wire logic divRun = (bpState == SLB_BYPASS) || startBypass;
  wire logic [DIV_W-1:0] next_divReg = divRun ? next_divCount : DIV_RST;

  always_ff @(posedge clk)
  begin
    if (rst)
      bpState <= SLB_PASS;
    else
      bpState <= next_bpState;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      divCount <= DIV_RST;
    else
      divCount <= next_divReg;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      remainSec <= REMAIN_RST;
    else
      remainSec <= next_remainSec;
  end

  ////////////////////////////////////////////////////////////////////////
  // bypass output
  ////////////////////////////////////////////////////////////////////////

  // forced On from the entry edge itself, in step with bypassActive
  wire logic inBypass = (next_bpState == SLB_BYPASS);
  // Stop while a bypassed two-hand control is worked; timer keeps running
  wire logic twoHandTrip = inBypass && twoHandInput;
  // a released request passes the input through, even on the last tick
  wire logic expiring = (bpState == SLB_BYPASS) && bypass_request_node
    && expireNow;
  wire logic next_bypassActive = (next_bpState == SLB_BYPASS);
  wire logic next_bypassExpired = (next_bpState == SLB_EXPIRED);

  logic next_bypassOut;
  always_comb
  begin
    next_bypassOut = chanRun;
    if (twoHandTrip || expiring)
      next_bypassOut = 1'b0;
    else if (inBypass)
      next_bypassOut = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      bypassOut <= OUT_RST;
    else
      bypassOut <= next_bypassOut;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      bypassActive <= OUT_RST;
    else
      bypassActive <= next_bypassActive;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      bypassExpired <= OUT_RST;
    else
      bypassExpired <= next_bypassExpired;
  end

endmodule : slb_logic_core

// ==== rtl/slb_pkg.sv ====
// Purpose: shared constants and types for the safety logic and bypass core
// Assumes: 100 MHz system clock, synchronous active-high reset
// Notes: logic level 1 means On / Run, 0 means Off / Stop
package slb_pkg;

  // system clock
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS = 10;

  // one second of the bypass timer, in clock cycles
  localparam int unsigned SEC_TIME_NS = 1_000_000_000;
  localparam int unsigned SEC_CYCLES = SEC_TIME_NS / CLK_PERIOD_NS;

  // logic gate inputs
  localparam int unsigned GATE_MAX_IN = 5;
  localparam int unsigned GATE_MIN_IN = 2;
  localparam logic [2:0] GATE_MIN_IN_W = 3'h2;

  // bypass time limit, in seconds
  localparam int unsigned LIMIT_W = 16;
  localparam logic [15:0] LIMIT_MIN_SEC = 16'h0001;
  localparam logic [15:0] LIMIT_MAX_SEC = 16'hA8C0;

  // divider counter width, wide enough for one second
  localparam int unsigned DIV_W = 32;

  // reset values
  localparam logic OUT_RST = 1'b0;
  localparam logic [15:0] REMAIN_RST = 16'h0000;
  localparam logic [31:0] DIV_RST = 32'h00000000;

  // gate function select
  typedef enum logic [2:0] {
    SLB_AND,
    SLB_OR,
    SLB_NAND,
    SLB_NOR,
    SLB_XOR
  } slb_gate_op_t;

  // bypass sequencing
  typedef enum logic [1:0] {
    SLB_PASS,
    SLB_BYPASS,
    SLB_EXPIRED
  } slb_bp_state_t;

endpackage : slb_pkg

// ==== tb/slb_chan_model.sv ====
// Purpose: dual-channel safety input device
// Assumes: wanted state set by the bench
// Notes: complementary devices drive channel B inverted
`timescale 1ns/10ps
module slb_chan_model (
  // wanted state
  input wire logic run,
  input wire logic chanComplementary,
  // channel pins
  output logic chanA,
  output logic chanB
);
  assign chanA = run;
  assign chanB = chanComplementary ? !run : run;
endmodule : slb_chan_model

// ==== tb/slb_core_sva.sv ====
// Purpose: port assertions for the logic and bypass core
// Assumes: one clock, synchronous active-high reset
// Notes: gate check covers AND only, with all inputs used and none inverted
`timescale 1ns/10ps
module slb_core_sva
  import slb_pkg::*;
#(
  parameter int unsigned NUM_IN = 5,
  parameter int unsigned SEC_TICKS = 4
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // gate, inverter and latches
  input wire logic [NUM_IN-1:0] gateIn,
  input wire logic [NUM_IN-1:0] gateUsed,
  input wire logic [NUM_IN-1:0] gateInvertIn,
  input wire logic gateInvertOut,
  input wire slb_pkg::slb_gate_op_t gateOp,
  input wire logic gateOut,
  input wire logic notIn,
  input wire logic notOut,
  input wire logic latchSet,
  input wire logic latchReset,
  input wire logic rsOut,
  input wire logic srOut,
  // bypass
  input wire logic chanRun,
  input wire logic bypass_request_node,
  input wire logic twoHandInput,
  input wire logic [slb_pkg::LIMIT_W-1:0] bypassLimitSec,
  input wire logic bypassOut,
  input wire logic bypassActive,
  input wire logic bypassExpired
);
  logic [31:0] actCnt;
  logic [31:0] lim;
  wire andPlain = &gateUsed && gateInvertIn == '0 && !gateInvertOut &&
    gateOp == SLB_AND;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  // cycles spent bypassed, against the limit taken at entry
  always_ff @(posedge clk)
  begin
    actCnt <= (rst || !bypassActive) ? 32'h0 : actCnt + 32'h1;
    if (!bypassActive)
      lim <= (bypassLimitSec == '0) ? 32'h1 : 32'(bypassLimitSec);
  end
  sequence s_idle;
    !bypassActive && !bypassExpired && bypass_request_node;
  endsequence
  sequence s_req;
    bypass_request_node;
  endsequence
  property p_and;
    !$past(rst) && $past(andPlain) |-> gateOut == $past(&gateIn);
  endproperty
  a_and: assert property (p_and) else $error("gate wrong");
  property p_not;
    !$past(rst) |-> notOut == !$past(notIn);
  endproperty
  a_not: assert property (p_not) else $error("not wrong");
  property p_rs;
    !$past(rst) && $past(latchReset) |-> !rsOut;
  endproperty
  a_rs: assert property (p_rs) else $error("rs latch wrong");
  property p_sr;
    !$past(rst) && $past(latchSet) |-> srOut;
  endproperty
  a_sr: assert property (p_sr) else $error("sr latch wrong");
  property p_pass;
    !$past(rst) && !$past(bypass_request_node, 2) &&
      !$past(bypass_request_node) |-> bypassOut == $past(chanRun);
  endproperty
  a_pass: assert property (p_pass) else $error("pass wrong");
  property p_byp;
    bypassActive |-> bypassOut == !$past(twoHandInput);
  endproperty
  a_byp: assert property (p_byp) else $error("bypass out wrong");
  property p_go;
    s_idle ##1 s_req |-> ##[0:1] bypassActive;
  endproperty
  a_go: assert property (p_go) else $error("no bypass entry");
  property p_exp;
    bypassActive |-> actCnt <= lim * SEC_TICKS + 32'h2;
  endproperty
  a_exp: assert property (p_exp) else $error("bypass too long");
  property p_off;
    $fell(bypassActive) && bypassExpired |-> !bypassOut;
  endproperty
  a_off: assert property (p_off) else $error("expiry not off");
endmodule : slb_core_sva
bind slb_logic_core slb_core_sva #(.NUM_IN(NUM_IN),
  .SEC_TICKS(SEC_TICKS)) i_sva (.*);

// ==== tb/tb_top.sv ====
// Purpose: random and corner tests of the logic and bypass core
// Assumes: one second shortened to four clock cycles
// Notes: xorshift stimulus from a fixed seed
`timescale 1ns/10ps
module tb_top;
  import slb_pkg::*;
  localparam int unsigned TICKS = 4;
  logic clk, rst, gateInvertOut, gateOut, notIn, notOut, latchSet;
  logic latchReset, rsOut, srOut, chanA, chanB, chanComplementary, chanRun;
  logic bypass_request_node, twoHandInput, bypassOut, bypassActive;
  logic bypassExpired, run, eG, eRs, eSr;
  logic [4:0] gateIn, gateUsed, gateInvertIn;
  logic [15:0] bypassLimitSec;
  logic [31:0] seed, r;
  slb_gate_op_t gateOp;
  int mismatches, checked, cyc;
  slb_logic_core #(.NUM_IN(5), .SEC_TICKS(TICKS)) i_dut (.*);
  slb_chan_model i_chan (.*);
  always #5 clk = !clk;
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic gexp(logic [4:0] i, u, v, logic o,
    slb_gate_op_t op);
    logic [4:0] e;
    logic y;
    e = (i ^ v) & u;
    case (op)
      SLB_AND: y = (e == u);
      SLB_OR: y = |e;
      SLB_NAND: y = (e != u);
      SLB_NOR: y = !(|e);
      default: y = ($countones(e) == 1);
    endcase
    return ($countones(u) < 2) ? 1'b0 : y ^ o;
  endfunction : gexp
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      mismatches++;
      wrap_up();
    end
  end
  task automatic time_bypass(logic [15:0] lim, logic hands);
    int cnt;
    int expCyc;
    logic ok;
    run = 1'b0;
    bypass_request_node = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    bypassLimitSec = lim;
    bypass_request_node = 1'b1;
    expCyc = ((lim == 0) ? 1 : lim) * TICKS;
    repeat (2) @(posedge clk);
    #1;
    check("bypassOut", bypassOut, 1'b1);
    check("bypassActive", bypassActive, 1'b1);
    bypassLimitSec = 16'h0007;
    twoHandInput = hands;
    repeat (2) @(posedge clk);
    #1;
    check("bypassOut", bypassOut, !hands);
    twoHandInput = 1'b0;
    cnt = 4;
    while (bypassExpired !== 1'b1 && cnt < 200)
    begin
      @(posedge clk);
      #1;
      cnt++;
    end
    check("bypassOut", bypassOut, 1'b0);
    check("bypassActive", bypassActive, 1'b0);
    ok = cnt >= expCyc - 1 && cnt <= expCyc + 3;
    check("bypass length", ok, 1'b1);
    run = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    check("bypassOut", bypassOut, 1'b1);
  endtask : time_bypass
  initial
  begin
    clk = 0;
    rst = 1;
    seed = 32'h000156DF;
    {gateIn, gateUsed, gateInvertIn, gateInvertOut, notIn} = '0;
    {latchSet, latchReset, chanComplementary, run, twoHandInput} = '0;
    {bypass_request_node, eRs, eSr} = '0;
    bypassLimitSec = 16'h0002;
    gateOp = SLB_AND;
    repeat (20) @(posedge clk);
    #1;
    rst = 0;
    for (int n = 0; n < 300; n++)
    begin
      @(posedge clk);
      #1;
      if (n > 0)
      begin
        check("gateOut", gateOut, eG);
        check("notOut", notOut, !notIn);
        check("rsOut", rsOut, eRs);
        check("srOut", srOut, eSr);
      end
      r = rnd();
      gateUsed = (n < 5) ? 5'h03 : (n < 10) ? 5'h04 : r[9:5];
      gateUsed = (n >= 10 && n < 60) ? 5'h1F : gateUsed;
      gateIn = (n < 10) ? 5'h1F : r[4:0];
      gateInvertIn = (n < 60) ? 5'h00 : r[14:10];
      gateInvertOut = (n < 60) ? 1'b0 : r[15];
      gateOp = slb_gate_op_t'(3'((n < 10) ? n % 5 : r[18:16] % 5));
      {notIn, latchSet, latchReset} = r[23:21];
      eG = gexp(gateIn, gateUsed, gateInvertIn, gateInvertOut, gateOp);
      eRs = !latchReset & (latchSet | eRs);
      eSr = latchSet | (!latchReset & eSr);
    end
    $display("gate and latch test done");
    for (int k = 0; k < 4; k++)
    begin
      {chanComplementary, run} = 2'(k);
      repeat (5) @(posedge clk);
      #1;
      check("chanRun", chanRun, run);
      check("bypassOut", bypassOut, run);
    end
    $display("channel test done");
    time_bypass(16'h0002, 1'b1);
    time_bypass(16'h0003, 1'b0);
    time_bypass(16'h0000, 1'b1);
    $display("bypass test done");
    wrap_up();
  end
endmodule : tb_top
